// ### pkg/sic_pkg.sv
// Overview of operation
// - Queue priority comes from five sources
// - Non-static sources map through traffic class table
// - Static address entry priority selects queue directly
// - Default priority is ingress port default VLAN priority
// - Precedence mode uses top three TOS bits
// - DS mode indexes table with upper six bits
// - VLAN mode remaps tag priority per port
// - VLAN table holds sixteen VID entries
// - Valid tagged VID searches table; hit applies entry
// - Table miss gives empty membership; checked packets drop
// - Empty membership with unknown destination is filtered
// - Untagged or VID zero uses port default VLAN
// - Membership drives ingress, egress and flood containment
// - Un-tag instructions apply only on hybrid ports
// - State 00 forwards, transmits and learns
// - State 01 discards and blocks transmissions
// - State 11 discards, blocks, no learning
// - State 10 discards, blocks, still learns
// - Static override entry bypasses port states
// - Non-forwarding source or destination is filtered
package sic_pkg;
  localparam int NPORT = 3;
  localparam int NVLAN = 16;
  localparam int AW = 8;
  localparam int DW = 32;
  // Register byte addresses
  localparam logic [AW-1:0] A_GCFG = 8'h00;
  localparam logic [AW-1:0] A_PSTATE = 8'h04;
  localparam logic [AW-1:0] A_PVID0 = 8'h08;
  localparam logic [AW-1:0] A_REGEN0 = 8'h14;
  localparam logic [AW-1:0] A_TC = 8'h20;
  localparam logic [AW-1:0] A_HYB = 8'h24;
  localparam logic [AW-1:0] A_DS = 8'h28;
  localparam logic [AW-1:0] A_VDATA = 8'h2c;
  localparam logic [AW-1:0] A_VCMD = 8'h30;
  localparam logic [AW-1:0] A_STAT = 8'h34;
  localparam int A_STEP = 4;
  // Global config bits
  localparam int G_DA_PRIO = 0;
  localparam int G_PREC = 1;
  localparam int G_DS = 2;
  localparam int G_VPRIO = 3;
  localparam int G_VLAN_EN = 4;
  localparam int G_MEMB_CHK = 5;
  localparam int G_W = 6;
  // Port default entry: VID low, priority above
  localparam int PV_PRIO_LSB = 12;
  localparam int PV_W = 15;
  localparam logic [PV_W-1:0] PV_RST = 15'h0001;
  // DS command: index low, value at DS_VAL_LSB
  localparam int DS_VAL_LSB = 8;
  localparam int TOS_PREC_LSB = 5;
  localparam int TOS_DS_LSB = 2;
  // VLAN entry layout
  localparam int VE_MEM_LSB = 12;
  localparam int VE_UNT_LSB = 15;
  localparam int VE_VALID = 18;
  localparam int VE_W = 19;
  localparam logic [11:0] VID_NULL = 12'h000;
  localparam logic [11:0] VID_RSVD = 12'hfff;
  // Spanning tree states
  localparam logic [1:0] ST_FWD = 2'h0;
  localparam logic [1:0] ST_BLK = 2'h1;
  localparam logic [1:0] ST_LRN = 2'h2;
  localparam logic [1:0] ST_LSN = 2'h3;
  // Identity regeneration and even traffic class spread
  localparam logic [23:0] REGEN_RST = 24'hfac688;
  localparam logic [15:0] TC_RST = 16'hfa50;
  localparam int STAT_SRC_LSB = 4;
  typedef enum logic [2:0] {PS_DA, PS_PREC, PS_DS, PS_VLAN, PS_DFLT} sic_psrc_type;
endpackage

// ### pkg/sic_vlan_if.sv
`timescale 1ns/1ps
interface sic_vlan_if;
  import sic_pkg::*;
  logic [11:0] lk_vid;
  logic lk_hit;
  logic [NPORT-1:0] lk_member;
  logic [NPORT-1:0] lk_untag;
  logic wr;
  logic [3:0] idx;
  logic [VE_W-1:0] wdata;
  logic [VE_W-1:0] rdata;
  modport table_side (input lk_vid, wr, idx, wdata, output lk_hit, lk_member, lk_untag, rdata);
  modport user_side (output lk_vid, wr, idx, wdata, input lk_hit, lk_member, lk_untag, rdata);
endinterface

// ### src/sic_vlan_table.sv
`timescale 1ns/1ps
module sic_vlan_table
  import sic_pkg::*;
(
  input wire logic mclk_i, // Core clock
  input wire logic srst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  sic_vlan_if.table_side vif // Lookup and host access
);
  logic [VE_W-1:0] ent_q [NVLAN];
  logic [NVLAN-1:0] match;
  logic [NVLAN:0][NPORT-1:0] mem_acc;
  logic [NVLAN:0][NPORT-1:0] unt_acc;

  assign mem_acc[0] = '0;
  assign unt_acc[0] = '0;

  // ----------------------------------------
  // Per-entry storage and search
  // ----------------------------------------
  for (genvar i = 0; i < NVLAN; i++)
  begin : g_ent
    always_ff @(posedge mclk_i)
    begin
      if (srst_i)
        ent_q[i] <= '0;
      else if (ce_i && vif.wr && vif.idx == 4'(i))
        ent_q[i] <= vif.wdata;
    end
    assign match[i] = ent_q[i][VE_VALID] && ent_q[i][11:0] == vif.lk_vid;
    assign mem_acc[i+1] = mem_acc[i] | (match[i] ? ent_q[i][VE_MEM_LSB +: NPORT] : '0);
    assign unt_acc[i+1] = unt_acc[i] | (match[i] ? ent_q[i][VE_UNT_LSB +: NPORT] : '0);
  end

  assign vif.lk_hit = |match;
  assign vif.lk_member = mem_acc[NVLAN];
  assign vif.lk_untag = unt_acc[NVLAN];
  assign vif.rdata = ent_q[vif.idx];
endmodule // sic_vlan_table

// ### src/sic_classifier.sv
`timescale 1ns/1ps
module sic_classifier
  import sic_pkg::*;
(
  input wire logic mclk_i, // Core clock
  input wire logic srst_i, // Sync reset, high
  input wire logic ce_i, // Clock enable
  input wire logic [AW-1:0] addr_i, // Register address
  input wire logic [DW-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [DW-1:0] rdata_o, // Read data
  input wire logic pkt_valid_i, // Packet descriptor valid
  input wire logic [1:0] pkt_src_i, // Ingress port 0..2
  input wire logic pkt_tagged_i, // Frame carries VLAN tag
  input wire logic [11:0] pkt_vid_i, // Tag VID
  input wire logic [2:0] pkt_pcp_i, // Tag priority
  input wire logic pkt_ipv4_i, // IPv4 frame
  input wire logic pkt_ipv6_i, // IPv6 frame
  input wire logic [7:0] pkt_tos_i, // TOS or traffic class octet
  input wire logic da_hit_i, // Destination found in address table
  input wire logic da_static_i, // Entry is static
  input wire logic da_override_i, // Entry age bit (override)
  input wire logic [1:0] da_prio_i, // Entry queue value
  input wire logic [NPORT-1:0] da_ports_i, // Entry destinations
  output logic dec_valid_o, // Decision valid pulse
  output logic [1:0] dec_queue_o, // Transmit queue
  output logic [2:0] dec_prio_o, // Selected priority
  output logic [11:0] dec_vid_o, // Resolved VID
  output logic [NPORT-1:0] dec_dest_o, // Destination ports
  output logic [NPORT-1:0] dec_untag_o, // Strip tag per port
  output logic dec_drop_o, // Packet filtered
  output logic dec_learn_o // Learn source address
);
  sic_vlan_if vif ();

  logic [G_W-1:0] gcfg_q;
  logic [2*NPORT-1:0] pstate_q;
  logic [NPORT-1:0][PV_W-1:0] port_default_vlan_id_q;
  logic [NPORT-1:0][7:0][2:0] regen_q;
  logic [7:0][1:0] tc_q;
  logic [NPORT-1:0] hyb_q;
  logic [2:0] ds_mem [64];
  logic [5:0] ds_idx_q;
  logic [VE_W-1:0] vstage_q;
  logic [3:0] vidx_q;
  sic_psrc_type src_q;

  logic wr_en;
  logic [NPORT-1:0] port_fwd;
  logic [NPORT-1:0][1:0] port_st;
  logic [NPORT-1:0] wr_port_default_vlan_id;
  logic [NPORT-1:0] wr_regen;
  logic [NPORT-1:0][DW-1:0] rd_port_default_vlan_id;
  logic [NPORT-1:0][DW-1:0] rd_regen;

  logic use_port_default_vlan_id;
  logic ovr;
  logic [1:0] sp;
  logic [NPORT-1:0] sbit;
  logic [11:0] eff_vid;
  sic_psrc_type psrc;
  logic [2:0] prio;
  logic [1:0] tc_sel;
  logic [1:0] queue;
  logic [NPORT-1:0] member;
  logic [NPORT-1:0] dest;
  logic drop;
  logic learn;

  assign wr_en = ce_i && wr_i;

  // ----------------------------------------
  // Per-port state, defaults and regeneration
  // ----------------------------------------
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    assign port_st[p] = pstate_q[2*p +: 2];
    assign port_fwd[p] = port_st[p] == ST_FWD;
    assign wr_port_default_vlan_id[p] = wr_en && addr_i == AW'(A_PVID0 + p * A_STEP);
    assign wr_regen[p] = wr_en && addr_i == AW'(A_REGEN0 + p * A_STEP);
    assign rd_port_default_vlan_id[p] = DW'(port_default_vlan_id_q[p]);
    assign rd_regen[p] = DW'(regen_q[p]);
    always_ff @(posedge mclk_i)
    begin
      if (srst_i)
        port_default_vlan_id_q[p] <= PV_RST;
      else if (wr_port_default_vlan_id[p])
        port_default_vlan_id_q[p] <= wdata_i[PV_W-1:0];
    end
    always_ff @(posedge mclk_i)
    begin
      if (srst_i)
        regen_q[p] <= REGEN_RST;
      else if (wr_regen[p])
        regen_q[p] <= wdata_i[23:0];
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      gcfg_q <= '0;
    else if (wr_en && addr_i == A_GCFG)
      gcfg_q <= wdata_i[G_W-1:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      pstate_q <= '0;
    else if (wr_en && addr_i == A_PSTATE)
      pstate_q <= wdata_i[2*NPORT-1:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      tc_q <= TC_RST;
    else if (wr_en && addr_i == A_TC)
      tc_q <= wdata_i[15:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      hyb_q <= '0;
    else if (wr_en && addr_i == A_HYB)
      hyb_q <= wdata_i[NPORT-1:0];
  end

  // Contents stay undefined until the host loads every entry
  always_ff @(posedge mclk_i)
  begin
    if (wr_en && addr_i == A_DS)
      ds_mem[wdata_i[5:0]] <= wdata_i[DS_VAL_LSB +: 3];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      ds_idx_q <= '0;
    else if (wr_en && addr_i == A_DS)
      ds_idx_q <= wdata_i[5:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      vstage_q <= '0;
    else if (wr_en && addr_i == A_VDATA)
      vstage_q <= wdata_i[VE_W-1:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      vidx_q <= '0;
    else if (wr_en && addr_i == A_VCMD)
      vidx_q <= wdata_i[3:0];
  end

  // ----------------------------------------
  // VLAN table
  // ----------------------------------------
  assign vif.wr = wr_en && addr_i == A_VCMD;
  assign vif.idx = vif.wr ? wdata_i[3:0] : vidx_q;
  assign vif.wdata = vstage_q;
  assign vif.lk_vid = eff_vid;

  sic_vlan_table u_vtab (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .vif(vif.table_side)
  );

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  always_comb
  begin
    sp = (pkt_src_i < 2'(NPORT)) ? pkt_src_i : 2'h0;
    sbit = NPORT'(1) << sp;
    use_port_default_vlan_id = !pkt_tagged_i || pkt_vid_i == VID_NULL;
    eff_vid = use_port_default_vlan_id ? port_default_vlan_id_q[sp][11:0] : pkt_vid_i;
    ovr = da_hit_i && da_static_i && da_override_i;
    // Source order: static entry, tag, precedence, DS, default
    if (gcfg_q[G_DA_PRIO] && da_hit_i && da_static_i)
    begin
      psrc = PS_DA;
      prio = 3'(da_prio_i);
    end
    else if (gcfg_q[G_VPRIO] && pkt_tagged_i)
    begin
      psrc = PS_VLAN;
      prio = regen_q[sp][pkt_pcp_i];
    end
    else if (gcfg_q[G_PREC] && pkt_ipv4_i)
    begin
      psrc = PS_PREC;
      prio = pkt_tos_i[TOS_PREC_LSB +: 3];
    end
    else if (gcfg_q[G_DS] && (pkt_ipv4_i || pkt_ipv6_i))
    begin
      psrc = PS_DS;
      prio = ds_mem[pkt_tos_i[TOS_DS_LSB +: 6]];
    end
    else
    begin
      psrc = PS_DFLT;
      prio = port_default_vlan_id_q[sp][PV_PRIO_LSB +: 3];
    end
    tc_sel = tc_q[prio];
    queue = (psrc == PS_DA) ? da_prio_i : tc_sel;
    if (gcfg_q[G_VLAN_EN])
      member = vif.lk_hit ? vif.lk_member : '0;
    else
      member = '1;
    dest = da_hit_i ? da_ports_i : member;
    if (gcfg_q[G_VLAN_EN] && gcfg_q[G_MEMB_CHK])
      dest = dest & member;
    dest = dest & ~sbit;
    if (!ovr)
      dest = dest & port_fwd;
    drop = (!port_fwd[sp] && !ovr) || dest == '0;
    if (gcfg_q[G_VLAN_EN] && pkt_tagged_i && pkt_vid_i == VID_RSVD)
      drop = 1'b1;
    if (gcfg_q[G_VLAN_EN] && gcfg_q[G_MEMB_CHK] && !member[sp])
      drop = 1'b1;
    learn = port_st[sp] == ST_FWD || port_st[sp] == ST_LRN;
  end

  // ----------------------------------------
  // Decision outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      dec_valid_o <= 1'b0;
    else if (ce_i)
      dec_valid_o <= pkt_valid_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      dec_queue_o <= '0;
      dec_prio_o <= '0;
      dec_vid_o <= '0;
      dec_dest_o <= '0;
      dec_untag_o <= '0;
      dec_drop_o <= 1'b0;
      dec_learn_o <= 1'b0;
      src_q <= PS_DFLT;
    end
    else if (ce_i && pkt_valid_i)
    begin
      dec_queue_o <= queue;
      dec_prio_o <= prio;
      dec_vid_o <= eff_vid;
      dec_dest_o <= drop ? '0 : dest;
      dec_untag_o <= (gcfg_q[G_VLAN_EN] && vif.lk_hit) ? (vif.lk_untag & hyb_q) : '0;
      dec_drop_o <= drop;
      dec_learn_o <= learn;
      src_q <= psrc;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      rdata_o <= '0;
    else if (ce_i && rd_i)
    begin
      rdata_o <= '0;
      for (int p = 0; p < NPORT; p++)
      begin
        if (addr_i == AW'(A_PVID0 + p * A_STEP))
          rdata_o <= rd_port_default_vlan_id[p];
        if (addr_i == AW'(A_REGEN0 + p * A_STEP))
          rdata_o <= rd_regen[p];
      end
      unique case (addr_i)
        A_GCFG: rdata_o <= DW'(gcfg_q);
        A_PSTATE: rdata_o <= DW'(pstate_q);
        A_TC: rdata_o <= DW'(tc_q);
        A_HYB: rdata_o <= DW'(hyb_q);
        A_DS: rdata_o <= DW'({ds_mem[ds_idx_q], 2'h0, ds_idx_q});
        A_VDATA: rdata_o <= DW'(vstage_q);
        A_VCMD: rdata_o <= DW'(vif.rdata);
        A_STAT: rdata_o <= DW'({src_q, dec_learn_o, dec_drop_o, dec_queue_o});
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  logic chk;
  assign chk = ce_i && pkt_valid_i;

  property p_src_block;
    chk && !ovr && !port_fwd[sp] |=> dec_drop_o && dec_dest_o == '0;
  endproperty
  a_src_block: assert property (p_src_block) else $error("non-forwarding source passed");

  property p_da_direct;
    chk && gcfg_q[G_DA_PRIO] && da_hit_i && da_static_i |=> dec_queue_o == $past(da_prio_i);
  endproperty
  a_da_direct: assert property (p_da_direct) else $error("static queue not direct");

  property p_prec;
    chk && psrc == PS_PREC |=> dec_prio_o == $past(pkt_tos_i[7:5]);
  endproperty
  a_prec: assert property (p_prec) else $error("precedence priority wrong");

  property p_tc_map;
    chk && psrc != PS_DA && !(wr_en && addr_i == A_TC) |=> dec_queue_o == tc_q[dec_prio_o];
  endproperty
  a_tc_map: assert property (p_tc_map) else $error("traffic class map bypassed");

  property p_listen_nolearn;
    chk && port_st[sp] == ST_LSN |=> !dec_learn_o && (dec_drop_o || $past(ovr));
  endproperty
  a_listen_nolearn: assert property (p_listen_nolearn) else $error("listen port learned");

  property p_learning;
    chk && port_st[sp] == ST_LRN |=> dec_learn_o;
  endproperty
  a_learning: assert property (p_learning) else $error("learning port did not learn");

  property p_foreign;
    chk && gcfg_q[G_VLAN_EN] && gcfg_q[G_MEMB_CHK] && !vif.lk_hit |=> dec_drop_o;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign VLAN not filtered");

  property p_port_default_vlan_id;
    chk && use_port_default_vlan_id |=> dec_vid_o == $past(port_default_vlan_id_q[sp][11:0]);
  endproperty
  a_port_default_vlan_id: assert property (p_port_default_vlan_id) else $error("default VID not applied");

  property p_override;
    chk && ovr && !gcfg_q[G_VLAN_EN] |=> dec_dest_o == $past(da_ports_i & ~sbit);
  endproperty
  a_override: assert property (p_override) else $error("override did not bypass state");

  c_drop: cover property (chk && drop);
  c_ds: cover property (chk && psrc == PS_DS);
  c_ovr: cover property (chk && ovr && !port_fwd[sp]);
endmodule // sic_classifier

// ### test/sic_parser_model.sv
`timescale 1ns/1ps
module sic_parser_model
  import sic_pkg::*;
(
  input wire logic mclk_i, // Core clock
  output logic pkt_valid_o, // Descriptor valid
  output logic [1:0] pkt_src_o, // Ingress port
  output logic pkt_tagged_o, // Tag present
  output logic [11:0] pkt_vid_o, // Tag VID
  output logic [2:0] pkt_pcp_o, // Tag priority
  output logic pkt_ipv4_o, // IPv4 frame
  output logic pkt_ipv6_o, // IPv6 frame
  output logic [7:0] pkt_tos_o, // TOS or traffic class octet
  output logic da_hit_o, // Lookup hit
  output logic da_static_o, // Static entry
  output logic da_override_o, // Age bit
  output logic [1:0] da_prio_o, // Entry queue
  output logic [NPORT-1:0] da_ports_o // Entry ports
);
  logic [35:0] fld_q;

  assign {pkt_src_o, pkt_tagged_o, pkt_vid_o, pkt_pcp_o, pkt_ipv4_o, pkt_ipv6_o, pkt_tos_o,
    da_hit_o, da_static_o, da_override_o, da_prio_o, da_ports_o} = fld_q;

  initial
  begin
    pkt_valid_o = 1'b0;
    fld_q = 36'h0;
  end

  // One-cycle descriptor; afterwards fields show the inverse so stale values never match
  task automatic send(input logic [35:0] f);
    @(posedge mclk_i);
    fld_q <= f;
    pkt_valid_o <= 1'b1;
    @(posedge mclk_i);
    pkt_valid_o <= 1'b0;
    fld_q <= ~f;
  endtask
endmodule // sic_parser_model

// ### test/switch_ingress_classifier_tb_top.sv
`timescale 1ns/1ps
module switch_ingress_classifier_tb_top;
  import sic_pkg::*;
  logic mclk, srst, ce, wr, rd, dv, drop, learn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic pv, tg, v4, v6, hit, sta, ovr;
  logic [1:0] src, dpr, dq;
  logic [11:0] vid, dvid;
  logic [2:0] pcp, dpt, dp, ddst, dunt;
  logic [7:0] tos;
  int err_total;
  int tests_run;

  sic_classifier dut (.mclk_i(mclk), .srst_i(srst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pkt_valid_i(pv), .pkt_src_i(src), .pkt_tagged_i(tg),
    .pkt_vid_i(vid), .pkt_pcp_i(pcp), .pkt_ipv4_i(v4), .pkt_ipv6_i(v6), .pkt_tos_i(tos),
    .da_hit_i(hit), .da_static_i(sta), .da_override_i(ovr), .da_prio_i(dpr), .da_ports_i(dpt),
    .dec_valid_o(dv), .dec_queue_o(dq), .dec_prio_o(dp), .dec_vid_o(dvid), .dec_dest_o(ddst),
    .dec_untag_o(dunt), .dec_drop_o(drop), .dec_learn_o(learn));

  sic_parser_model partner (.mclk_i(mclk), .pkt_valid_o(pv), .pkt_src_o(src),
    .pkt_tagged_o(tg), .pkt_vid_o(vid), .pkt_pcp_o(pcp), .pkt_ipv4_o(v4), .pkt_ipv6_o(v6),
    .pkt_tos_o(tos), .da_hit_o(hit), .da_static_o(sta), .da_override_o(ovr),
    .da_prio_o(dpr), .da_ports_o(dpt));

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask

  function automatic logic [35:0] fr(input logic [1:0] s, input logic t, input logic [11:0] v,
    input logic [2:0] c, input logic [1:0] ip, input logic [7:0] o, input logic [2:0] hso,
    input logic [1:0] pr, input logic [2:0] pt);
    return {s, t, v, c, ip, o, hso, pr, pt};
  endfunction

  function automatic logic [1:0] tcq(input int p);
    return TC_RST[2*p +: 2];
  endfunction

  // Sends one descriptor and judges the decision that follows it
  task automatic pkt(input logic [35:0] f, input logic [1:0] q, input logic [2:0] p,
    input logic [11:0] v, input logic [2:0] dst, unt, input logic drp, lrn);
    int n;
    partner.send(f);
    #1;
    n = 0;
    while (dv !== 1'b1 && n < 4)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 4)
    begin
      err_total++;
      stop_test();
    end
    chk("queue", 32'(dq), 32'(q));
    chk("prio", 32'(dp), 32'(p));
    chk("vid", 32'(dvid), 32'(v));
    chk("dest", 32'(ddst), 32'(dst));
    chk("untag", 32'(dunt), 32'(unt));
    chk("drop", 32'(drop), 32'(drp));
    chk("learn", 32'(learn), 32'(lrn));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(A_GCFG, 32'h0);
    rchk(A_PSTATE, 32'h0);
    rchk(A_PVID0, 32'(PV_RST));
    rchk(A_REGEN0, 32'(REGEN_RST));
    rchk(A_TC, 32'(TC_RST));
    rchk(A_HYB, 32'h0);
    rchk(8'h3c, 32'h0);
  endtask

  task automatic t_prio();
    wreg(A_PVID0 + 8'(A_STEP), 32'h0000_5001);
    pkt(fr(2'h1, 1'b0, 12'h0, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(5), 3'h5, 12'h001, 3'h5, 3'h0, 1'b0, 1'b1);
    wreg(A_GCFG, 32'h0000_0003);
    pkt(fr(2'h0, 1'b0, 12'h0, 3'h0, 2'h2, 8'ha0, 3'h6, 2'h1, 3'h4),
      2'h1, 3'h1, 12'h001, 3'h4, 3'h0, 1'b0, 1'b1);
    pkt(fr(2'h0, 1'b0, 12'h0, 3'h0, 2'h2, 8'ha0, 3'h4, 2'h1, 3'h4),
      tcq(5), 3'h5, 12'h001, 3'h4, 3'h0, 1'b0, 1'b1);
    for (int i = 0; i < 64; i++)
      wreg(A_DS, {21'h0, 3'(i) ^ 3'h5, 2'h0, 6'(i)});
    rchk(A_DS, 32'h0000_023f);
    wreg(A_GCFG, 32'h0000_0004);
    pkt(fr(2'h0, 1'b0, 12'h0, 3'h0, 2'h1, 8'had, 3'h0, 2'h0, 3'h0),
      tcq(6), 3'h6, 12'h001, 3'h6, 3'h0, 1'b0, 1'b1);
    wreg(A_REGEN0 + 8'(A_STEP), {8'h0, REGEN_RST[23:9], 3'h7, REGEN_RST[5:0]});
    wreg(A_GCFG, 32'h0000_0008);
    pkt(fr(2'h1, 1'b1, 12'h0, 3'h2, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(7), 3'h7, 12'h001, 3'h5, 3'h0, 1'b0, 1'b1);
  endtask

  task automatic t_vlan();
    wreg(A_VDATA, 32'h0005_b123);
    wreg(A_VCMD, 32'h0000_000f);
    rchk(A_VCMD, 32'h0005_b123);
    rchk(A_VDATA, 32'h0005_b123);
    wreg(A_HYB, 32'h0000_0002);
    wreg(A_GCFG, 32'h0000_0030);
    pkt(fr(2'h0, 1'b1, 12'h123, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(0), 3'h0, 12'h123, 3'h2, 3'h2, 1'b0, 1'b1);
    pkt(fr(2'h0, 1'b1, 12'h456, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(0), 3'h0, 12'h456, 3'h0, 3'h0, 1'b1, 1'b1);
    pkt(fr(2'h0, 1'b1, 12'hfff, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(0), 3'h0, 12'hfff, 3'h0, 3'h0, 1'b1, 1'b1);
    // Untag follows the VLAN hit even when the packet is filtered
    pkt(fr(2'h2, 1'b1, 12'h123, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(0), 3'h0, 12'h123, 3'h0, 3'h2, 1'b1, 1'b1);
    wreg(A_GCFG, 32'h0000_0010);
    pkt(fr(2'h0, 1'b1, 12'h456, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0),
      tcq(0), 3'h0, 12'h456, 3'h0, 3'h0, 1'b1, 1'b1);
    pkt(fr(2'h0, 1'b1, 12'h456, 3'h0, 2'h0, 8'h0, 3'h4, 2'h0, 3'h2),
      tcq(0), 3'h0, 12'h456, 3'h2, 3'h0, 1'b0, 1'b1);
    wreg(A_GCFG, 32'h0);
  endtask

  task automatic t_stp();
    logic [2:0] ed;
    for (int s = 0; s < 4; s++)
    begin
      wreg(A_PSTATE, 32'(s) << 2);
      ed = (s == 0) ? 3'h1 : 3'h0;
      pkt(fr(2'h1, 1'b0, 12'h0, 3'h0, 2'h0, 8'h0, 3'h4, 2'h0, 3'h1),
        tcq(5), 3'h5, 12'h001, ed, 3'h0, s != 0, s == 0 || s == 2);
    end
    wreg(A_PSTATE, 32'h0000_0004);
    pkt(fr(2'h1, 1'b0, 12'h0, 3'h0, 2'h0, 8'h0, 3'h7, 2'h0, 3'h1),
      tcq(5), 3'h5, 12'h001, 3'h1, 3'h0, 1'b0, 1'b0);
    wreg(A_PSTATE, 32'h0000_0030);
    pkt(fr(2'h0, 1'b0, 12'h0, 3'h0, 2'h0, 8'h0, 3'h4, 2'h0, 3'h4),
      tcq(0), 3'h0, 12'h001, 3'h0, 3'h0, 1'b1, 1'b1);
    rchk(A_STAT, 32'h0000_004c);
  endtask

  // Clock enable low must ignore register writes and packets
  task automatic t_ce();
    @(posedge mclk);
    ce <= 1'b0;
    wreg(A_HYB, 32'h0000_0007);
    partner.send(fr(2'h1, 1'b0, 12'h0, 3'h0, 2'h0, 8'h0, 3'h0, 2'h0, 3'h0));
    #1;
    chk("frozen_valid", 32'(dv), 32'h0);
    chk("frozen_drop", 32'(drop), 32'h1);
    @(posedge mclk);
    ce <= 1'b1;
    rchk(A_HYB, 32'h0000_0002);
  endtask

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    err_total = 0;
    tests_run = 0;
    srst = 1'b1;
    ce = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_prio();
    t_vlan();
    t_stp();
    t_ce();
    stop_test();
  end
endmodule // switch_ingress_classifier_tb_top
